/* File: hw/dwp_map.vh */
// constants for the dual wiper two-wire slave
`ifndef DWP_MAP_VH
`define DWP_MAP_VH
`define DWP_CTRL_CODE 4'h5
`define DWP_CMD_WR0 8'hA9
`define DWP_CMD_WR1 8'hAA
`define DWP_CMD_WRB 8'hAF
`define DWP_WIPER_RST 8'h00
`define DWP_ST_IDLE 3'h0
`define DWP_ST_ADDR 3'h1
`define DWP_ST_WACK 3'h2
`define DWP_ST_WRX 3'h3
`define DWP_ST_TX 3'h4
`define DWP_ST_TACK 3'h5
`define DWP_BIT_LAST 3'h7
`endif

/* File: hw/dwp_slave.v */
// two-wire slave serving two 8-bit wiper position registers
// How it works
// - control byte upper nibble must be 0101 to respond
// - control bits 3..1 compared with three strapped select inputs
// - control bit 0 one means read, zero means write
// - acknowledge the control byte only on full match
// - every byte shifted most significant bit first
// - receiver drives ninth-bit acknowledge; device for bytes it receives
// - read sends wiper 0 first after the control acknowledge
// - after master ack of wiper 0, send wiper 1
// - write is control with direction zero, ack, then command byte
// - commands A9 wiper 0, AA wiper 1, AF both wipers
// - wiper 0 command: first data to wiper 0, second to wiper 1
// - wiper 1 command: data to wiper 1 only
// - both command: one data byte loads both wipers
// - both wipers clear to 00h at reset
// - after master nack, release the data line
`include "dwp_map.vh"
`timescale 1ns/100ps
`default_nettype none
module dwp_slave (
    input wire clk_sys,
    input wire sys_rst,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_r,
    input wire select_pin_bit0,
    input wire select_pin_bit1,
    input wire select_pin_bit2,
    output reg [7:0] first_wiper_output,
    output reg [7:0] second_wiper_output
);
    reg scl_s1_r, scl_s2_r, scl_d_r;
    reg sda_s1_r, sda_s2_r, sda_d_r;
    reg [2:0] sel_s1_r, sel_s2_r;
    reg [2:0] state_r;
    reg [2:0] bit_r;
    reg [7:0] shift_r;
    reg [1:0] byte_r;
    reg [7:0] cmd_r;
    reg rd_r;
    reg commit_r;
    reg full_r; // eight bits taken since the last byte boundary
    wire scl_rise, scl_fall, start_det, stop_det;
    wire [7:0] rx_byte;

    assign sda_out = 1'b0; // open drain: only ever pulls low
    assign scl_rise = scl_s2_r & ~scl_d_r;
    assign scl_fall = ~scl_s2_r & scl_d_r;
    assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
    assign rx_byte = {shift_r[6:0], sda_s2_r};

    // two-flop synchronisers for pins
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
            sel_s1_r <= 3'h0;
            sel_s2_r <= 3'h0;
        end else begin
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
            sel_s1_r <= {select_pin_bit2, select_pin_bit1, select_pin_bit0};
            sel_s2_r <= sel_s1_r;
        end
    end

    // protocol state machine and wiper registers
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= `DWP_ST_IDLE;
            bit_r <= 3'h0;
            shift_r <= 8'h00;
            byte_r <= 2'h0;
            cmd_r <= 8'h00;
            rd_r <= 1'b0;
            commit_r <= 1'b0;
            full_r <= 1'b0;
            sda_oe_r <= 1'b0;
            first_wiper_output <= `DWP_WIPER_RST;
            second_wiper_output <= `DWP_WIPER_RST;
        end else if (start_det) begin
            state_r <= `DWP_ST_ADDR;
            bit_r <= 3'h0;
            byte_r <= 2'h0;
            commit_r <= 1'b0;
            full_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= `DWP_ST_IDLE;
            commit_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            case (state_r)
                `DWP_ST_IDLE: begin
                    sda_oe_r <= 1'b0;
                end
                `DWP_ST_ADDR: begin
                    if (scl_rise) begin
                        shift_r <= rx_byte;
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == `DWP_BIT_LAST)
                            full_r <= 1'b1;
                    end
                    if (scl_fall && full_r) begin
                        // eighth bit taken on the last rising edge
                        full_r <= 1'b0;
                        if (shift_r[7:4] == `DWP_CTRL_CODE &&
                                shift_r[3:1] == sel_s2_r) begin
                            rd_r <= shift_r[0];
                            sda_oe_r <= 1'b1;
                            state_r <= `DWP_ST_WACK;
                        end else begin
                            state_r <= `DWP_ST_IDLE;
                        end
                    end
                end
                `DWP_ST_WACK: begin
                    // end of our acknowledge slot
                    if (scl_fall) begin
                        bit_r <= 3'h0;
                        if (commit_r) begin
                            commit_r <= 1'b0;
                            case (cmd_r)
                                `DWP_CMD_WR0: begin
                                    if (byte_r == 2'h2)
                                        first_wiper_output <= shift_r;
                                    else if (byte_r == 2'h3)
                                        second_wiper_output <= shift_r;
                                end
                                `DWP_CMD_WR1: begin
                                    if (byte_r == 2'h2)
                                        second_wiper_output <= shift_r;
                                end
                                `DWP_CMD_WRB: begin
                                    if (byte_r == 2'h2) begin
                                        first_wiper_output <= shift_r;
                                        second_wiper_output <= shift_r;
                                    end
                                end
                                default: begin
                                    sda_oe_r <= 1'b0;
                                end
                            endcase
                            if (byte_r == 2'h3)
                                cmd_r <= 8'h00; // extra bytes ignored
                        end
                        if (rd_r && byte_r == 2'h0) begin
                            shift_r <= first_wiper_output;
                            sda_oe_r <= ~first_wiper_output[7];
                            byte_r <= 2'h1;
                            state_r <= `DWP_ST_TX;
                        end else begin
                            sda_oe_r <= 1'b0;
                            // count bytes after the ack so the commit sees its own index
                            if (byte_r != 2'h3)
                                byte_r <= byte_r + 2'h1;
                            state_r <= `DWP_ST_WRX;
                        end
                    end
                end
                `DWP_ST_WRX: begin
                    if (scl_rise) begin
                        shift_r <= rx_byte;
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == `DWP_BIT_LAST)
                            full_r <= 1'b1;
                    end
                    if (scl_fall && full_r) begin
                        // full byte in: ack it
                        full_r <= 1'b0;
                        sda_oe_r <= 1'b1;
                        if (byte_r == 2'h1)
                            cmd_r <= shift_r;
                        commit_r <= (byte_r != 2'h1); // data bytes commit at ack end
                        state_r <= `DWP_ST_WACK;
                    end
                end
                `DWP_ST_TX: begin
                    if (scl_fall) begin
                        if (bit_r == `DWP_BIT_LAST) begin
                            sda_oe_r <= 1'b0; // master drives ack
                            state_r <= `DWP_ST_TACK;
                        end else begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            sda_oe_r <= ~shift_r[6];
                            bit_r <= bit_r + 3'h1;
                        end
                    end
                end
                `DWP_ST_TACK: begin
                    if (scl_rise) begin
                        if (sda_s2_r) begin
                            state_r <= `DWP_ST_IDLE;
                        end else begin
                            bit_r <= 3'h0;
                            rd_r <= 1'b1;
                            shift_r <= (byte_r == 2'h1) ? second_wiper_output : 8'hFF;
                            byte_r <= 2'h2;
                        end
                    end
                    if (scl_fall && !sda_s2_r) begin
                        sda_oe_r <= ~shift_r[7];
                        state_r <= `DWP_ST_TX;
                    end
                end
                default: begin
                    state_r <= `DWP_ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: tb/dwp_slave_properties.sv */
// port checker for the dual wiper two-wire slave
`timescale 1ns/100ps
`default_nettype none
module dwp_slave_properties (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_r,
    input wire logic select_pin_bit0,
    input wire logic select_pin_bit1,
    input wire logic select_pin_bit2,
    input wire logic [7:0] first_wiper_output,
    input wire logic [7:0] second_wiper_output
);
    logic [3:0] hi_cnt_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // saturating run length of steady high scl
    always @(posedge clk_sys) begin
        hi_cnt_r <= (sys_rst || !scl_in) ? 4'h0 : hi_cnt_r + {3'h0, hi_cnt_r != 4'hF};
    end
    sequence s_ack_up; $rose(sda_oe_r); endsequence
    sequence s_ack_held; sda_oe_r [*6]; endsequence
    a_rst_clear: assert property (disable iff (1'b0)
        sys_rst |=> !sda_oe_r && first_wiper_output == 8'h00 && second_wiper_output == 8'h00)
        else $error("reset left wipers or sda set");
    a_drive_low: assert property (sda_out == 1'b0)
        else $error("sda driven to a high level");
    a_oe_scl_low: assert property ($changed(sda_oe_r) |-> !$past(scl_in, 2))
        else $error("sda changed outside scl low");
    a_oe_scl_high: assert property ($past(scl_in) && scl_in |-> $stable(sda_oe_r))
        else $error("sda moved while scl high");
    a_wiper_commit: assert property (
        $changed(first_wiper_output) || $changed(second_wiper_output) |-> !$past(scl_in, 2))
        else $error("wiper changed outside scl low");
    a_ack_hold: assert property (s_ack_up |-> s_ack_held)
        else $error("low bit not held a full pulse");
    a_idle_quiet: assert property (hi_cnt_r >= 4'hA |-> !sda_oe_r)
        else $error("sda pulled while bus idle");
    a_oe_release: assert property (s_ack_up |-> ##[1:100] !sda_oe_r)
        else $error("sda never released");
endmodule
bind dwp_slave dwp_slave_properties u_prop (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_r(sda_oe_r),
    .select_pin_bit0(select_pin_bit0), .select_pin_bit1(select_pin_bit1),
    .select_pin_bit2(select_pin_bit2), .first_wiper_output(first_wiper_output),
    .second_wiper_output(second_wiper_output));
`default_nettype wire

/* File: tb/dwp_i2c_master.sv */
// behavioural two-wire bus master facing the slave
`timescale 1ns/100ps
`default_nettype none
module dwp_i2c_master (
    input wire logic clk_sys,
    input wire logic sda_in,
    output logic scl,
    output logic sda_oe
);
    // clock stands high and data released between frames
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic hc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // one pulse: data set early in low phase, sampled mid high
    task automatic bit_tx(input logic b, output logic r);
        hc(1);
        sda_oe = !b;
        hc(3);
        scl = 1'b1;
        hc(2);
        r = sda_in;
        hc(2);
        scl = 1'b0;
    endtask
    task automatic start;
        sda_oe = 1'b1;
        hc(4);
        scl = 1'b0;
    endtask
    task automatic stop;
        hc(1);
        sda_oe = 1'b1;
        hc(3);
        scl = 1'b1;
        hc(4);
        sda_oe = 1'b0;
        hc(8);
    endtask
    // control, command and data bytes, msb first, ninth bit left to receiver
    task automatic byte_wr(input logic [7:0] d, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bit_tx(d[i], r);
        bit_tx(1'b1, a);
    endtask
    // ack to ask for more, nack on the last byte
    task automatic byte_rd(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_tx(1'b1, d[i]);
        bit_tx(nack, r);
    endtask
endmodule
`default_nettype wire

/* File: tb/dwp_slave_tb.sv */
// self-checking bench for the dual wiper two-wire slave
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module dwp_slave_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] sel = 3'h5;
    logic scl, mst_oe, sda_out, sda_oe_r, ack;
    logic [7:0] w0, w1, rd0, rd1, c, d1, d2, n, e0, e1;
    int n_mismatch = 0;
    int compares = 0;
    // command, data, data, byte count, expected wiper 0 and wiper 1
    logic [47:0] rows [7] = '{48'hA91200011200, 48'hA93456023456, 48'hAA7800013478,
        48'hAF9C00019C9C, 48'h551100019C9C, 48'hAF0102020101, 48'hAAC35A0201C3};
    wire sda = !mst_oe && !(sda_oe_r && !sda_out);
    always #25 clk_sys = !clk_sys;
    dwp_slave dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_r(sda_oe_r), .select_pin_bit0(sel[0]),
        .select_pin_bit1(sel[1]), .select_pin_bit2(sel[2]),
        .first_wiper_output(w0), .second_wiper_output(w1));
    dwp_i2c_master u_mst (.clk_sys(clk_sys), .sda_in(sda), .scl(scl), .sda_oe(mst_oe));
    task automatic wr(input [7:0] ctl, cmd, x1, x2, k, output logic a);
        logic r;
        u_mst.start();
        u_mst.byte_wr(ctl, a);
        if (a === 1'b0) begin
            u_mst.byte_wr(cmd, r);
            `CHK(r, 1'b0)
            u_mst.byte_wr(x1, r);
            `CHK(r, 1'b0)
            if (k == 8'h02) begin
                u_mst.byte_wr(x2, r);
                `CHK(r, 1'b0)
            end
        end
        u_mst.stop();
    endtask
    task automatic rd(input [7:0] k);
        logic a;
        u_mst.start();
        u_mst.byte_wr({4'h5, sel, 1'b1}, a);
        `CHK(a, 1'b0)
        u_mst.byte_rd(k == 8'h01, rd0);
        if (k == 8'h02) u_mst.byte_rd(1'b1, rd1);
        u_mst.stop();
    endtask
    task automatic results;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        `CHK(w0, 8'h00)
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        foreach (rows[i]) begin
            {c, d1, d2, n, e0, e1} = rows[i];
            wr({4'h5, sel, 1'b0}, c, d1, d2, n, ack);
            `CHK(ack, 1'b0)
            `CHK(w0, e0)
            `CHK(w1, e1)
            rd(8'h02);
            `CHK(rd0, e0)
            `CHK(rd1, e1)
        end
        wr({4'h6, sel, 1'b0}, 8'hA9, 8'hEE, 8'h00, 8'h01, ack);
        `CHK(ack, 1'b1)
        wr({4'h5, sel ^ 3'h1, 1'b0}, 8'hAF, 8'hEE, 8'h00, 8'h01, ack);
        `CHK(ack, 1'b1)
        `CHK(w1, 8'hC3)
        sel = 3'h2;
        repeat (8) @(negedge clk_sys);
        wr({4'h5, sel, 1'b0}, 8'hAF, 8'h66, 8'h00, 8'h01, ack);
        `CHK(w0, 8'h66)
        rd(8'h01);
        `CHK(rd0, 8'h66)
        `CHK(sda_oe_r, 1'b0)
        sys_rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK(w1, 8'h00)
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        results();
    end
    // cuts a hang short well past the expected run length
    initial begin
        #1000000;
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
